// ### rtl/sspr_rx_map.sv
// Receive slot map for channels 6 to 8 of the secondary serial port.
`timescale 1ns/10ps

// Summary of operation
// [RULE_01] Ch6 source 0 ignores data, 1 feeds DAC6.
// [RULE_02] Ch6 source 2 feeds ADC2 loopback path.
// [RULE_03] Ch6 source 3 feeds linked device 1.
// [RULE_04] Ch7 source field two bits, resets zero.
// [RULE_05] Ch7 source 2 ADC3 loopback, 3 linked 2.
// [RULE_06] Ch8 sources: off, DAC8, ADC4 loopback, linked 3.
// [RULE_07] Slot values 0-15: TDM slot or left slot.
// [RULE_08] Slot values 16-31: TDM slot or right slot.
// [RULE_09] Reset values 0x05, 0x06, 0x07: disabled, slots 5-7.
// [RULE_10] Bit 7 reserved, reads zero, writes ignored.
// [RULE_11] Ch8 slot field bits 4-0, resets slot 7.
// [RULE_12] Disabled channel captures and forwards nothing.
module sspr_rx_map
  import sspr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic REG_WE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic FMT_TDM,
  input wire logic BCLK,
  input wire logic FSYNC,
  input wire logic DIN,
  output logic [31:0] CH6_DATA,
  output logic CH6_DAC_VLD,
  output logic CH6_LOOP_VLD,
  output logic CH6_LINK_VLD,
  output logic [31:0] CH7_DATA,
  output logic CH7_DAC_VLD,
  output logic CH7_LOOP_VLD,
  output logic CH7_LINK_VLD,
  output logic [31:0] CH8_DATA,
  output logic CH8_DAC_VLD,
  output logic CH8_LOOP_VLD,
  output logic CH8_LINK_VLD
);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // Stored bits 6..0 of each channel register; bit 7 has no storage.
  logic [6:0] cfg_r [SSPR_NUM_CH];
  // Offsets and reset values indexed by channel.
  logic [7:0] ofs [SSPR_NUM_CH];
  logic [7:0] rst_val [SSPR_NUM_CH];

  assign ofs[0] = SSPR_CH6_OFS;
  assign ofs[1] = SSPR_CH7_OFS;
  assign ofs[2] = SSPR_CH8_OFS;
  assign rst_val[0] = SSPR_CH6_RST;
  assign rst_val[1] = SSPR_CH7_RST;
  assign rst_val[2] = SSPR_CH8_RST;

  // Each register takes a write at its own offset. The reserved bit is dropped
  // so it can never hold anything but its reset value of zero.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg_r[0] <= SSPR_CH6_RST[6:0]; // see [RULE_09]
      cfg_r[1] <= SSPR_CH7_RST[6:0]; // see [RULE_09] see [RULE_04]
      cfg_r[2] <= SSPR_CH8_RST[6:0]; // see [RULE_09] see [RULE_11]
    end
    else if (REG_WE)
    begin
      for (int i = 0; i < SSPR_NUM_CH; i++)
      begin
        if (REG_ADDR == ofs[i])
        begin
          cfg_r[i] <= REG_WDATA[6:0]; // see [RULE_10]
        end
      end
    end
  end

  // Read mux. Unmapped offsets read zero, and bit 7 is always zero.
  always_comb
  begin
    REG_RDATA = 8'h00;
    for (int i = 0; i < SSPR_NUM_CH; i++)
    begin
      if (REG_ADDR == ofs[i])
      begin
        REG_RDATA = {1'b0, cfg_r[i]}; // see [RULE_10]
      end
    end
  end

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Two-stage synchronisers for the serial pins; only stage two is read.
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  // Previous synchronised bit clock level, for edge detection.
  logic bclk_prev_r;

  // The serial pins come from the host's clock domain.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      bclk_prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {BCLK, FSYNC, DIN};
      sync2_r <= sync1_r;
      bclk_prev_r <= sync2_r[2];
    end
  end

  // Synchronised pin levels.
  logic bclk_s;
  logic fsync_s;
  logic din_s;
  assign bclk_s = sync2_r[2];
  assign fsync_s = sync2_r[1];
  assign din_s = sync2_r[0];

  // Data is sampled on the rising bit clock edge. The bit clock must be slower
  // than half of CLK for the edge detector to see every edge.
  logic bit_stb;
  assign bit_stb = bclk_s && !bclk_prev_r;

  // ==========================================================================
  // Frame position
  // ==========================================================================
  // Frame sync level seen at the previous bit.
  logic fsync_prev_r;
  // Bits counted since the frame or half start; upper five bits are the slot.
  logic [9:0] cnt_r;
  // Half being received in the two-half formats; high for the right half.
  logic half_r;
  // Frame or half starts on this bit.
  logic start;
  // Position of the current bit.
  logic [9:0] pos;
  logic half_now;

  // TDM frames start on a rising frame sync; the two-half formats restart the
  // count on each change of frame sync, high marking the left half.
  always_comb
  begin
    if (FMT_TDM)
    begin
      start = fsync_s && !fsync_prev_r;
    end
    else
    begin
      start = (fsync_s != fsync_prev_r);
    end
    pos = start ? SSPR_CNT_RST : cnt_r;
    half_now = start ? !fsync_s : half_r;
  end

  // Bit counter and half tracking, advanced once per bit.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      fsync_prev_r <= 1'b0;
      cnt_r <= SSPR_CNT_RST;
      half_r <= 1'b0;
    end
    else if (bit_stb)
    begin
      fsync_prev_r <= fsync_s;
      half_r <= half_now;
      if (start)
      begin
        cnt_r <= SSPR_CNT_AFTER_START;
      end
      else
      begin
        cnt_r <= cnt_r + 10'h001;
      end
    end
  end

  // ==========================================================================
  // Channel capture and routing
  // ==========================================================================
  // Per-channel captured words and delivery pulses.
  logic [31:0] word [SSPR_NUM_CH];
  logic word_vld [SSPR_NUM_CH];
  // Per-channel routing pulses.
  logic dac_vld [SSPR_NUM_CH];
  logic loop_vld [SSPR_NUM_CH];
  logic link_vld [SSPR_NUM_CH];

  generate
    for (genvar g = 0; g < SSPR_NUM_CH; g++)
    begin : g_ch
      // Source and slot fields of this channel.
      logic [1:0] src;
      assign src = cfg_r[g][SSPR_SRC_MSB:SSPR_SRC_LSB];

      sspr_slot_capture u_cap
      (
        .clk (CLK),
        .rst (RST),
        .bit_stb (bit_stb),
        .din (din_s),
        .tdm_mode (FMT_TDM),
        .slot_cnt (pos[9:5]),
        .bit_idx (pos[4:0]),
        .half_right (half_now),
        .src (src),
        .slot_sel (cfg_r[g][SSPR_SLOT_MSB:0]),
        .word_r (word[g]),
        .word_vld_r (word_vld[g])
      );

      // The word goes to exactly one path chosen by the source field; a
      // disabled channel forwards nothing.
      assign dac_vld[g] = word_vld[g] && (src == SSPR_SRC_DAC); // see [RULE_01] see [RULE_04]
      assign loop_vld[g] = word_vld[g] && (src == SSPR_SRC_LOOP); // see [RULE_02] see [RULE_05]
      assign link_vld[g] = word_vld[g] && (src == SSPR_SRC_LINK); // see [RULE_03] see [RULE_06]
    end
  endgenerate

  assign CH6_DATA = word[0];
  assign CH6_DAC_VLD = dac_vld[0];
  assign CH6_LOOP_VLD = loop_vld[0];
  assign CH6_LINK_VLD = link_vld[0];
  assign CH7_DATA = word[1];
  assign CH7_DAC_VLD = dac_vld[1];
  assign CH7_LOOP_VLD = loop_vld[1];
  assign CH7_LINK_VLD = link_vld[1];
  assign CH8_DATA = word[2];
  assign CH8_DAC_VLD = dac_vld[2];
  assign CH8_LOOP_VLD = loop_vld[2];
  assign CH8_LINK_VLD = link_vld[2];

  // ==========================================================================
  // Checks
  // ==========================================================================
  // A write to channel 7 followed by a read of it.
  sequence s_wr_ch7;
    REG_WE && (REG_ADDR == SSPR_CH7_OFS);
  endsequence

  sequence s_rd_ch7;
    !REG_WE && (REG_ADDR == SSPR_CH7_OFS);
  endsequence

  a_ch7_readback : assert property (@(posedge CLK) disable iff (RST) // see [RULE_04]
    s_wr_ch7 ##1 s_rd_ch7 |-> REG_RDATA == {1'b0, $past(REG_WDATA[6:0])})
    else $error("channel 7 register did not read back the written value");

  a_rsv_reads_zero : assert property (@(posedge CLK) disable iff (RST) // see [RULE_10]
    !REG_RDATA[SSPR_RSV_BIT])
    else $error("reserved bit read as one");

  a_reset_values : assert property (@(posedge CLK) // see [RULE_09]
    RST |-> (cfg_r[0] == 7'h05) && (cfg_r[1] == 7'h06) && (cfg_r[2] == 7'h07))
    else $error("configuration not at reset value during reset");

  a_ch6_dac_route : assert property (@(posedge CLK) disable iff (RST) // see [RULE_01]
    CH6_DAC_VLD |-> (g_ch[0].src == SSPR_SRC_DAC) && !CH6_LOOP_VLD && !CH6_LINK_VLD)
    else $error("channel 6 DAC pulse on wrong source");

  a_ch6_loop_route : assert property (@(posedge CLK) disable iff (RST) // see [RULE_02]
    (word_vld[0] && (g_ch[0].src == SSPR_SRC_LOOP)) |-> CH6_LOOP_VLD && !CH6_DAC_VLD)
    else $error("channel 6 loopback word not routed");

  a_ch6_link_route : assert property (@(posedge CLK) disable iff (RST) // see [RULE_03]
    (word_vld[0] && (g_ch[0].src == SSPR_SRC_LINK)) |-> CH6_LINK_VLD)
    else $error("channel 6 linked word not routed");

  a_ch7_paths : assert property (@(posedge CLK) disable iff (RST) // see [RULE_05]
    CH7_LINK_VLD || CH7_LOOP_VLD |-> word_vld[1] && g_ch[1].src[1])
    else $error("channel 7 path pulse on wrong source");

  a_ch8_paths : assert property (@(posedge CLK) disable iff (RST) // see [RULE_06]
    word_vld[2] |-> (CH8_DAC_VLD + CH8_LOOP_VLD + CH8_LINK_VLD) == 2'h1)
    else $error("channel 8 word not routed to exactly one path");

  a_ch8_slot_hold : assert property (@(posedge CLK) disable iff (RST) // see [RULE_11]
    !(REG_WE && (REG_ADDR == SSPR_CH8_OFS)) |=> $stable(cfg_r[2]))
    else $error("channel 8 slot changed without a write");

  // A DAC pulse on channel 7 only ever comes from a delivered word with the DAC code.
  a_ch7_dac_route : assert property (@(posedge CLK) disable iff (RST) // see [RULE_04]
    CH7_DAC_VLD |-> word_vld[1] && (g_ch[1].src == SSPR_SRC_DAC))
    else $error("channel 7 DAC pulse on wrong source");

  // Every frame or half start leaves the count at the second bit of slot zero.
  a_cnt_restart : assert property (@(posedge CLK) disable iff (RST) // see [RULE_07]
    bit_stb && start |=> cnt_r == SSPR_CNT_AFTER_START)
    else $error("bit count did not restart at frame start");

  // In the two-half formats a start with the sync low opens the right half.
  a_half_follows : assert property (@(posedge CLK) disable iff (RST) // see [RULE_08]
    bit_stb && start && !FMT_TDM |=> half_r == !$past(fsync_s))
    else $error("half tracking did not follow the frame sync");

endmodule : sspr_rx_map

// ### rtl/sspr_pkg.sv
// Package with register map, field layout and slot framing constants for the receive slot map.
package sspr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Byte offsets of the three channel configuration registers.
  localparam logic [7:0] SSPR_CH6_OFS = 8'h2D;
  localparam logic [7:0] SSPR_CH7_OFS = 8'h2E;
  localparam logic [7:0] SSPR_CH8_OFS = 8'h2F;

  // Reset values: channel disabled, slot 5, 6 and 7 assigned.
  localparam logic [7:0] SSPR_CH6_RST = 8'h05;
  localparam logic [7:0] SSPR_CH7_RST = 8'h06;
  localparam logic [7:0] SSPR_CH8_RST = 8'h07;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  // Reserved bit, source field and slot field positions.
  localparam int SSPR_RSV_BIT = 7;
  localparam int SSPR_SRC_MSB = 6;
  localparam int SSPR_SRC_LSB = 5;
  localparam int SSPR_SLOT_MSB = 4;
  // Number of channels held by this block.
  localparam int SSPR_NUM_CH = 3;

  // Source selection codes of the two-bit source field.
  typedef enum logic [1:0]
  {
    SSPR_SRC_OFF = 2'h0,
    SSPR_SRC_DAC = 2'h1,
    SSPR_SRC_LOOP = 2'h2,
    SSPR_SRC_LINK = 2'h3
  } sspr_src_t;

  // ==========================================================================
  // Serial framing
  // ==========================================================================
  // Bits per slot, and the index of the last bit in a slot.
  localparam int SSPR_SLOT_BITS = 32;
  localparam logic [4:0] SSPR_LAST_BIT = 5'h1F;
  // Value the bit counter takes after the first bit of a frame or half.
  localparam logic [9:0] SSPR_CNT_AFTER_START = 10'h001;
  // Counter value at reset.
  localparam logic [9:0] SSPR_CNT_RST = 10'h000;

endpackage : sspr_pkg

// ### rtl/sspr_slot_capture.sv
// One receive channel: slot matching, bit capture and word delivery.
`timescale 1ns/10ps

module sspr_slot_capture
  import sspr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_stb,
  input wire logic din,
  input wire logic tdm_mode,
  input wire logic [4:0] slot_cnt,
  input wire logic [4:0] bit_idx,
  input wire logic half_right,
  input wire logic [1:0] src,
  input wire logic [4:0] slot_sel,
  output logic [31:0] word_r,
  output logic word_vld_r
);

  // ==========================================================================
  // Slot match
  // ==========================================================================
  // High while the current serial bit belongs to this channel's slot.
  logic slot_hit;
  // High on a bit strobe that this channel must capture.
  logic capture;
  // Bits of the word collected so far.
  logic [30:0] shift_r;

  // In TDM the five-bit field is the slot number itself; in the two-half formats
  // the top bit picks the half and the lower four bits the slot within it.
  always_comb
  begin
    if (tdm_mode)
    begin
      slot_hit = (slot_cnt == slot_sel); // see [RULE_07] see [RULE_08]
    end
    else
    begin
      // Slots beyond 15 in a half do not exist, so they never match.
      slot_hit = (half_right == slot_sel[4]) && !slot_cnt[4] &&
                 (slot_cnt[3:0] == slot_sel[3:0]); // see [RULE_07] see [RULE_08]
    end
  end

  // A disabled channel takes nothing from its slot, whatever the slot field says.
  assign capture = bit_stb && slot_hit && (src != SSPR_SRC_OFF); // see [RULE_12]

  // ==========================================================================
  // Capture
  // ==========================================================================
  // Shift register collecting the slot MSB first.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= '0;
    end
    else if (capture)
    begin
      shift_r <= {shift_r[29:0], din};
    end
  end

  // Word and its one-cycle valid pulse at the last bit of the slot.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      word_r <= '0;
      word_vld_r <= 1'b0;
    end
    else
    begin
      word_vld_r <= capture && (bit_idx == SSPR_LAST_BIT);
      if (capture && (bit_idx == SSPR_LAST_BIT))
      begin
        word_r <= {shift_r, din};
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // A word is only delivered right after the last bit of a matching slot.
  a_word_after_match : assert property (@(posedge clk) disable iff (rst) // see [RULE_07]
    word_vld_r |-> $past(slot_hit) && $past(bit_stb) && ($past(bit_idx) == SSPR_LAST_BIT))
    else $error("word delivered without a matching last slot bit");

  // A disabled channel never delivers a word.
  a_off_no_word : assert property (@(posedge clk) disable iff (rst) // see [RULE_12]
    ($past(src) == SSPR_SRC_OFF) |-> !word_vld_r)
    else $error("disabled channel delivered a word");

endmodule : sspr_slot_capture

// ### tb/sspr_host_model.sv
// Behavioural audio host that drives serial frames into the receive slot map.
`timescale 1ns/10ps

// ============================================================================
// Host frame driver
// ============================================================================
module sspr_host_model
(
  output logic bclk,
  output logic fsync,
  output logic din
);
  // The bit clock stands still low between frames.
  initial
  begin
    bclk = 1'b0;
    fsync = 1'b0;
    din = 1'b0;
  end

  // Sends one frame of 32 slots of 32 bits, MSB first; slot s carries base ^ {s, 27'h0}.
  // In two-half format slots 16 to 31 form the right half, with the frame sync low.
  task automatic send_frame(input logic tdm, input logic [31:0] base);
    logic [31:0] w;
    #13;
    for (int s = 0; s < 32; s++)
    begin
      w = base ^ {5'(s), 27'h0};
      for (int b = 31; b >= 0; b--)
      begin
        // Data and sync change while the bit clock is low, ahead of its rise.
        fsync = tdm ? (s == 0 && b == 31) : (s < 16);
        din = w[b];
        #400;
        bclk = 1'b1;
        #400;
        bclk = 1'b0;
      end
    end
    // The line is released: show the inverse so a stale bit is never mistaken for data.
    din = ~din;
  endtask : send_frame
endmodule : sspr_host_model

// ### tb/tb_sspr_rx_map.sv
// Self-checking testbench for the receive slot map of channels 6 to 8.
`timescale 1ns/10ps

module tb_sspr_rx_map
  import sspr_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic we = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic fmt_tdm = 1'b1;
  logic bclk, fsync, din;
  logic [31:0] dat [3];
  logic [3:0] v [3];
  logic [4:0] sl [3];
  logic [31:0] got [3];
  int cnt [3][4];
  int fail_count = 0;
  int total_checks = 0;

  // Free running 10 MHz clock.
  always #50 clk = ~clk;

  sspr_host_model host (.bclk(bclk), .fsync(fsync), .din(din));

  sspr_rx_map DUT (
    .CLK(clk), .RST(rst), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .FMT_TDM(fmt_tdm), .BCLK(bclk), .FSYNC(fsync), .DIN(din),
    .CH6_DATA(dat[0]), .CH6_DAC_VLD(v[0][1]), .CH6_LOOP_VLD(v[0][2]),
    .CH6_LINK_VLD(v[0][3]), .CH7_DATA(dat[1]), .CH7_DAC_VLD(v[1][1]),
    .CH7_LOOP_VLD(v[1][2]), .CH7_LINK_VLD(v[1][3]), .CH8_DATA(dat[2]),
    .CH8_DAC_VLD(v[2][1]), .CH8_LOOP_VLD(v[2][2]), .CH8_LINK_VLD(v[2][3])
  );
  // Bit 0 of each pulse group is unused.
  assign v[0][0] = 1'b0;
  assign v[1][0] = 1'b0;
  assign v[2][0] = 1'b0;

  // ==========================================================================
  // Monitor
  // ==========================================================================
  // Pulses last one cycle, so every falling edge, midway through the pulse, is
  // watched and the word kept with it.
  always @(negedge clk)
  begin
    for (int c = 0; c < 3; c++)
    begin
      for (int k = 1; k < 4; k++)
      begin
        if (v[c][k] === 1'b1)
        begin
          cnt[c][k]++;
          got[c] = dat[c];
        end
      end
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One-cycle write strobe; the next access starts at a later edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
  endtask : wr

  // The read port is combinational, so it is sampled at the next rising edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(posedge clk);
    chk("read data", {24'h0, e}, {24'h0, rdata});
  endtask : rd

  // Configures all three channels, sends a frame and checks pulses and words.
  task automatic frame(input logic tdm, input logic [1:0] src, input logic [31:0] base);
    // The format pin changes on a falling edge like every other input.
    @(negedge clk);
    fmt_tdm = tdm;
    for (int c = 0; c < 3; c++)
    begin
      wr(SSPR_CH6_OFS + 8'(c), {1'b0, src, sl[c]});
    end
    cnt = '{default: 0};
    host.send_frame(tdm, base);
    repeat (8) @(negedge clk);
    for (int c = 0; c < 3; c++)
    begin
      for (int k = 1; k < 4; k++)
      begin
        chk("pulse count", {31'h0, (k == src)}, cnt[c][k]);
      end
      // A disabled channel must show no word at all, checked by the counts above.
      if (src != 2'h0)
      begin
        chk("channel word", base ^ {sl[c], 27'h0}, got[c]);
      end
    end
  endtask : frame

  // Prints the verdict and ends the run.
  task automatic close_out;
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    // Raising reset just after time zero gives the flops a clean reset edge
    // before the first clock edge, so nothing is unknown when it is checked.
    #1;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(SSPR_CH6_OFS, 8'h05);
    rd(SSPR_CH7_OFS, 8'h06);
    rd(SSPR_CH8_OFS, 8'h07);
    rd(8'h2C, 8'h00);
    // Software keeps the reserved bit at its reset value of zero.
    wr(SSPR_CH6_OFS, 8'h7F);
    rd(SSPR_CH6_OFS, 8'h7F);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
    rd(SSPR_CH8_OFS, 8'h07);
    // TDM: low, middle and top slot numbers, every source code.
    sl = '{5'h05, 5'h10, 5'h1F};
    frame(1'b1, 2'h0, 32'h1234ABCD);
    frame(1'b1, 2'h1, 32'h0F0F5AA5);
    frame(1'b1, 2'h2, 32'h00C3A55A);
    frame(1'b1, 2'h3, 32'h13579BDF);
    // Two-half: left slot 15, right slot 0 and right slot 15.
    sl = '{5'h0F, 5'h10, 5'h1F};
    frame(1'b0, 2'h1, 32'h02468ACE);
    close_out();
  end

  // Five frames take about 41000 cycles; the limit leaves ample margin.
  initial
  begin
    #6000000;
    fail_count++;
    close_out();
  end
endmodule : tb_sspr_rx_map
